// File: hdl/rcsec_defs.svh
`ifndef RCSEC_DEFS_SVH
`define RCSEC_DEFS_SVH

// Widths of the register path
`define RCSEC_ADDR_W 8
`define RCSEC_DATA_W 16
`define RCSEC_CHANNELS 4
`define RCSEC_FIELD_W 2
`define RCSEC_EN_W 4

// Register and command offsets
`define RCSEC_OFS_REFRESH 8'h00
`define RCSEC_OFS_RANGE 8'h1d
`define RCSEC_OFS_GCALL 8'h1e
`define RCSEC_OFS_KEEP 8'h1f
`define RCSEC_OFS_PINSTAT 8'h20

// Reset values
`define RCSEC_RANGE_RST 16'h0000
`define RCSEC_EDGE_EN_RST 4'h0
`define RCSEC_RDATA_RST 16'h0000

// Range configuration layout, channel 1 in the highest field
`define RCSEC_SENSE_LSB 8
`define RCSEC_BUS_LSB 0

// Range field codes
`define RCSEC_CODE_UNI 2'h0
`define RCSEC_CODE_BIP_FULL 2'h1
`define RCSEC_CODE_BIP_HALF 2'h2

// Pin-status register bit positions
`define RCSEC_BIT_LEVEL 7
`define RCSEC_BIT_RISE_SEEN 6
`define RCSEC_BIT_FALL_SEEN 5
`define RCSEC_EN_LSB 1

// Index of each action enable inside the 4-bit enable field
`define RCSEC_EN_RISE_FULL 3
`define RCSEC_EN_RISE_KEEP 2
`define RCSEC_EN_FALL_FULL 1
`define RCSEC_EN_FALL_KEEP 0

// Pin synchroniser must be full before edges are trusted
`define RCSEC_WARM_DONE 2'h3
`define RCSEC_WARM_STEP 2'h1

`endif

// File: hdl/rcsec_pkg.sv
package rcsec_pkg;
`include "rcsec_defs.svh"

   // Meaning of one range field
   typedef enum logic [1:0] {
      RCSEC_RANGE_UNI,
      RCSEC_RANGE_BIP_FULL,
      RCSEC_RANGE_BIP_HALF,
      RCSEC_RANGE_RSVD
   } rcsec_range_t;

   // Link-side request sequencer
   typedef enum logic {
      RCSEC_LK_IDLE,
      RCSEC_LK_WAIT
   } rcsec_lk_state_t;

   // All state of the link-side port
   typedef struct packed {
      rcsec_lk_state_t state;
      logic req_tgl;
      logic wr;
      logic [`RCSEC_ADDR_W-1:0] addr;
      logic [`RCSEC_DATA_W-1:0] wdata;
      logic ack_s1;
      logic ack_s2;
      logic ack_s3;
      logic [`RCSEC_DATA_W-1:0] rdata;
      logic done;
   } rcsec_link_st_t;

   // All state of the system-clock core
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic pin_s1;
      logic pin_s2;
      logic pin_prev;
      logic [1:0] warm;
      logic [`RCSEC_DATA_W-1:0] range_pend;
      logic [`RCSEC_DATA_W-1:0] range_act;
      logic [`RCSEC_CHANNELS-1:0] sense_bip;
      logic [`RCSEC_CHANNELS-1:0] sense_half;
      logic [`RCSEC_CHANNELS-1:0] sense_rsvd;
      logic [`RCSEC_CHANNELS-1:0] bus_bip;
      logic [`RCSEC_CHANNELS-1:0] bus_half;
      logic [`RCSEC_CHANNELS-1:0] bus_rsvd;
      logic rise_seen;
      logic fall_seen;
      logic [`RCSEC_EN_W-1:0] edge_en;
      logic ack_tgl;
      logic [`RCSEC_DATA_W-1:0] rdata;
      logic snap;
      logic clr;
      logic act;
   } rcsec_core_st_t;

endpackage

// File: hdl/rcsec_xfer_if.sv
`timescale 1ns/1ps
`include "rcsec_defs.svh"

// Toggle handshake between the link domain and the system-clock core
interface rcsec_xfer_if;
   logic req_tgl;
   logic wr;
   logic [`RCSEC_ADDR_W-1:0] addr;
   logic [`RCSEC_DATA_W-1:0] wdata;
   logic ack_tgl;
   logic [`RCSEC_DATA_W-1:0] rdata;

   modport lnk (
      output req_tgl,
      output wr,
      output addr,
      output wdata,
      input ack_tgl,
      input rdata
   );

   modport core (
      input req_tgl,
      input wr,
      input addr,
      input wdata,
      output ack_tgl,
      output rdata
   );
endinterface

// File: hdl/rcsec_link_port.sv
`timescale 1ns/1ps
`include "rcsec_defs.svh"

module rcsec_link_port (
   input wire logic lk_clk,
   input wire logic lk_rst_b,
   input wire logic lk_req,
   input wire logic lk_write,
   input wire logic [`RCSEC_ADDR_W-1:0] lk_addr,
   input wire logic [`RCSEC_DATA_W-1:0] lk_wdata,
   output logic lk_ready,
   output logic lk_done,
   output logic [`RCSEC_DATA_W-1:0] lk_rdata,
   rcsec_xfer_if.lnk xfer
);

   rcsec_pkg::rcsec_link_st_t q;
   rcsec_pkg::rcsec_link_st_t d;

   // Request words are held while waiting, so the core reads them stable
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.ack_s1 = xfer.ack_tgl;
      d.ack_s2 = q.ack_s1;
      d.ack_s3 = q.ack_s2;
      case (q.state)
         rcsec_pkg::RCSEC_LK_IDLE: begin
            if (lk_req) begin
               d.addr = lk_addr;
               d.wr = lk_write;
               d.wdata = lk_wdata;
               d.req_tgl = ~q.req_tgl;
               d.state = rcsec_pkg::RCSEC_LK_WAIT;
            end
         end
         rcsec_pkg::RCSEC_LK_WAIT: begin
            // Core has answered; its read word is stable by now
            if (q.ack_s2 ^ q.ack_s3) begin
               d.rdata = xfer.rdata;
               d.done = 1'b1;
               d.state = rcsec_pkg::RCSEC_LK_IDLE;
            end
         end
         default: begin
            d.state = rcsec_pkg::RCSEC_LK_IDLE;
         end
      endcase
   end

   // State register on the link clock
   always_ff @(posedge lk_clk) begin
      if (!lk_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs toward the link and the crossing
   assign lk_ready = (q.state == rcsec_pkg::RCSEC_LK_IDLE);
   assign lk_done = q.done;
   assign lk_rdata = q.rdata;
   assign xfer.req_tgl = q.req_tgl;
   assign xfer.wr = q.wr;
   assign xfer.addr = q.addr;
   assign xfer.wdata = q.wdata;

endmodule

// File: hdl/rcsec_top.sv
`timescale 1ns/1ps
`include "rcsec_defs.svh"

module rcsec_top (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic lk_clk,
   input wire logic lk_rst_b,
   input wire logic lk_req,
   input wire logic lk_write,
   input wire logic [`RCSEC_ADDR_W-1:0] lk_addr,
   input wire logic [`RCSEC_DATA_W-1:0] lk_wdata,
   output logic lk_ready,
   output logic lk_done,
   output logic [`RCSEC_DATA_W-1:0] lk_rdata,
   input wire logic rate_ovr_pin,
   output logic rate_ovr_level,
   output logic snapshot_pulse,
   output logic accum_clear_pulse,
   output logic config_activate_pulse,
   output logic [`RCSEC_DATA_W-1:0] range_active,
   output logic [`RCSEC_CHANNELS-1:0] sense_bipolar,
   output logic [`RCSEC_CHANNELS-1:0] sense_half_scale,
   output logic [`RCSEC_CHANNELS-1:0] sense_reserved,
   output logic [`RCSEC_CHANNELS-1:0] bus_bipolar,
   output logic [`RCSEC_CHANNELS-1:0] bus_half_scale,
   output logic [`RCSEC_CHANNELS-1:0] bus_reserved
);

   rcsec_pkg::rcsec_core_st_t q;
   rcsec_pkg::rcsec_core_st_t d;

   rcsec_xfer_if xfer ();

   // Link-clock side of the register path
   rcsec_link_port u_link (
      .lk_clk (lk_clk),
      .lk_rst_b (lk_rst_b),
      .lk_req (lk_req),
      .lk_write (lk_write),
      .lk_addr (lk_addr),
      .lk_wdata (lk_wdata),
      .lk_ready (lk_ready),
      .lk_done (lk_done),
      .lk_rdata (lk_rdata),
      .xfer (xfer.lnk)
   );

   // Pick one channel's field; channel 1 sits in the highest bits
   function automatic logic [`RCSEC_FIELD_W-1:0] rcsec_field(
      input logic [`RCSEC_DATA_W-1:0] rng,
      input int base,
      input int ch
   );
      int pos;
      pos = base + `RCSEC_FIELD_W * (`RCSEC_CHANNELS - 1 - ch);
      rcsec_field = rng[pos +: `RCSEC_FIELD_W];
   endfunction

   // Same code table for sense and bus fields; only the scale differs
   function automatic rcsec_pkg::rcsec_range_t rcsec_decode(
      input logic [`RCSEC_FIELD_W-1:0] code
   );
      case (code)
         `RCSEC_CODE_UNI: rcsec_decode = rcsec_pkg::RCSEC_RANGE_UNI;
         `RCSEC_CODE_BIP_FULL: rcsec_decode = rcsec_pkg::RCSEC_RANGE_BIP_FULL;
         `RCSEC_CODE_BIP_HALF: rcsec_decode = rcsec_pkg::RCSEC_RANGE_BIP_HALF;
         default: rcsec_decode = rcsec_pkg::RCSEC_RANGE_RSVD;
      endcase
   endfunction

   // Pin-status byte as software sees it, bit 0 always zero
   function automatic logic [`RCSEC_DATA_W-1:0] rcsec_status(
      input logic level,
      input logic rise,
      input logic fall,
      input logic [`RCSEC_EN_W-1:0] en
   );
      logic [`RCSEC_DATA_W-1:0] v;
      v = '0;
      v[`RCSEC_BIT_LEVEL] = level;
      v[`RCSEC_BIT_RISE_SEEN] = rise;
      v[`RCSEC_BIT_FALL_SEEN] = fall;
      v[`RCSEC_EN_LSB +: `RCSEC_EN_W] = en;
      rcsec_status = v;
   endfunction

   // Action of one pin edge as {full, keep}; full beats keep
   function automatic logic [1:0] rcsec_edge_act(
      input logic edge_seen,
      input logic en_full,
      input logic en_keep
   );
      logic full;
      logic keep;
      full = edge_seen & en_full;
      keep = edge_seen & en_keep & ~full;
      rcsec_edge_act = {full, keep};
   endfunction

   // Range flags of one field as {bipolar, half scale, reserved}
   function automatic logic [2:0] rcsec_flags(
      input rcsec_pkg::rcsec_range_t r
   );
      logic bip;
      logic half;
      logic rsvd;
      bip = (r == rcsec_pkg::RCSEC_RANGE_BIP_FULL) |
         (r == rcsec_pkg::RCSEC_RANGE_BIP_HALF);
      half = (r == rcsec_pkg::RCSEC_RANGE_BIP_HALF);
      rsvd = (r == rcsec_pkg::RCSEC_RANGE_RSVD);
      rcsec_flags = {bip, half, rsvd};
   endfunction

   // Read answer for one offset; commands and holes read as zero
   function automatic logic [`RCSEC_DATA_W-1:0] rcsec_read_word(
      input logic [`RCSEC_ADDR_W-1:0] a,
      input logic [`RCSEC_DATA_W-1:0] pend,
      input logic [`RCSEC_DATA_W-1:0] stat
   );
      case (a)
         `RCSEC_OFS_RANGE: begin
            rcsec_read_word = pend;
         end
         `RCSEC_OFS_PINSTAT: begin
            rcsec_read_word = stat;
         end
         default: begin
            rcsec_read_word = `RCSEC_RDATA_RST;
         end
      endcase
   endfunction

   // Core next-state logic on the system clock
   always_comb begin
      logic new_req;
      logic cmd_full;
      logic cmd_keep;
      logic rise;
      logic fall;
      logic lim_full;
      logic lim_keep;
      rcsec_pkg::rcsec_range_t sdec;
      rcsec_pkg::rcsec_range_t bdec;
      logic [1:0] rise_act;
      logic [1:0] fall_act;
      logic [2:0] sflags;
      logic [2:0] bflags;
      new_req = 1'b0;
      cmd_full = 1'b0;
      cmd_keep = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      lim_full = 1'b0;
      lim_keep = 1'b0;
      sdec = rcsec_pkg::RCSEC_RANGE_UNI;
      bdec = rcsec_pkg::RCSEC_RANGE_UNI;
      rise_act = 2'h0;
      fall_act = 2'h0;
      sflags = 3'h0;
      bflags = 3'h0;
      d = q;
      d.snap = 1'b0;
      d.clr = 1'b0;
      d.act = 1'b0;

      // Request toggle crosses in; stages two and three feed the detector
      d.req_s1 = xfer.req_tgl;
      d.req_s2 = q.req_s1;
      d.req_s3 = q.req_s2;
      new_req = q.req_s2 ^ q.req_s3;

      // Override pin is asynchronous to everything here
      d.pin_s1 = rate_ovr_pin;
      d.pin_s2 = q.pin_s1;
      d.pin_prev = q.pin_s2;
      if (q.warm != `RCSEC_WARM_DONE) begin
         d.warm = q.warm + `RCSEC_WARM_STEP;
      end

      // No edges until the synchroniser holds real pin samples,
      // so a pin already high at reset is not taken as a rise
      if (q.warm == `RCSEC_WARM_DONE) begin
         rise = q.pin_s2 & ~q.pin_prev;
         fall = ~q.pin_s2 & q.pin_prev;
      end

      // Link holds address and data until our ack, so reading is safe
      // Register access arriving from the link
      if (new_req) begin
         d.ack_tgl = ~q.ack_tgl;
         d.rdata = `RCSEC_RDATA_RST;
         if (q.req_s3 == q.req_s2) begin
            d.rdata = `RCSEC_RDATA_RST;
         end else if (xfer.wr) begin
            case (xfer.addr)
               `RCSEC_OFS_REFRESH: begin
                  cmd_full = 1'b1;
               end
               `RCSEC_OFS_GCALL: begin
                  cmd_full = 1'b1;
               end
               `RCSEC_OFS_KEEP: begin
                  cmd_keep = 1'b1;
               end
               `RCSEC_OFS_RANGE: begin
                  d.range_pend = xfer.wdata;
               end
               `RCSEC_OFS_PINSTAT: begin
                  // Only the enables are writable; flags and level ignore
                  d.edge_en = xfer.wdata[`RCSEC_EN_LSB +: `RCSEC_EN_W];
               end
               default: begin
                  d.rdata = `RCSEC_RDATA_RST;
               end
            endcase
         end else begin
            // Live status; no update command needed to see it
            d.rdata = rcsec_read_word(xfer.addr, q.range_pend,
               rcsec_status(q.pin_s2, q.rise_seen, q.fall_seen,
               q.edge_en));
         end
      end

      // Pin-edge actions; a full refresh wins when both are enabled
      rise_act = rcsec_edge_act(rise, q.edge_en[`RCSEC_EN_RISE_FULL],
         q.edge_en[`RCSEC_EN_RISE_KEEP]);
      fall_act = rcsec_edge_act(fall, q.edge_en[`RCSEC_EN_FALL_FULL],
         q.edge_en[`RCSEC_EN_FALL_KEEP]);
      // A rise and a fall never land in one cycle, so OR-ing is safe;
      // the mask still keeps keep from riding along with a full one
      lim_full = rise_act[1] | fall_act[1];
      lim_keep = (rise_act[0] | fall_act[0]) & ~lim_full;

      // Host commands activate pending ranges; limited actions never do
      if (cmd_full | cmd_keep) begin
         d.range_act = q.range_pend;
         d.act = 1'b1;
      end

      // Snapshot on every update; clear only for the full variants
      d.snap = cmd_full | cmd_keep | lim_full | lim_keep;
      d.clr = cmd_full | lim_full;

      // Sticky edge flags; a set in the clearing cycle wins
      if (cmd_full) begin
         d.rise_seen = 1'b0;
         d.fall_seen = 1'b0;
      end
      if (rise) begin
         d.rise_seen = 1'b1;
      end
      if (fall) begin
         d.fall_seen = 1'b1;
      end

      // Decode the active fields for the measurement datapath
      for (int i = 0; i < `RCSEC_CHANNELS; i++) begin
         sdec = rcsec_decode(rcsec_field(d.range_act, `RCSEC_SENSE_LSB, i));
         bdec = rcsec_decode(rcsec_field(d.range_act, `RCSEC_BUS_LSB, i));
         // Flags follow the next active value, so they move with it
         sflags = rcsec_flags(sdec);
         bflags = rcsec_flags(bdec);
         d.sense_bip[i] = sflags[2];
         d.sense_half[i] = sflags[1];
         d.sense_rsvd[i] = sflags[0];
         d.bus_bip[i] = bflags[2];
         d.bus_half[i] = bflags[1];
         d.bus_rsvd[i] = bflags[0];
      end
   end

   // State register on the system clock
   // Every field named, so none can slip out of reset
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q.req_s1 <= 1'b0;
         q.req_s2 <= 1'b0;
         q.req_s3 <= 1'b0;
         q.pin_s1 <= 1'b0;
         q.pin_s2 <= 1'b0;
         q.pin_prev <= 1'b0;
         q.warm <= 2'h0;
         q.range_pend <= `RCSEC_RANGE_RST;
         q.range_act <= `RCSEC_RANGE_RST;
         q.sense_bip <= 4'h0;
         q.sense_half <= 4'h0;
         q.sense_rsvd <= 4'h0;
         q.bus_bip <= 4'h0;
         q.bus_half <= 4'h0;
         q.bus_rsvd <= 4'h0;
         q.rise_seen <= 1'b0;
         q.fall_seen <= 1'b0;
         q.edge_en <= `RCSEC_EDGE_EN_RST;
         q.ack_tgl <= 1'b0;
         q.rdata <= `RCSEC_RDATA_RST;
         q.snap <= 1'b0;
         q.clr <= 1'b0;
         q.act <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Answer path back to the link domain
   assign xfer.ack_tgl = q.ack_tgl;
   assign xfer.rdata = q.rdata;

   // Registered outputs toward the datapath
   assign rate_ovr_level = q.pin_s2;
   assign snapshot_pulse = q.snap;
   assign accum_clear_pulse = q.clr;
   assign config_activate_pulse = q.act;
   assign range_active = q.range_act;
   assign sense_bipolar = q.sense_bip;
   assign sense_half_scale = q.sense_half;
   assign sense_reserved = q.sense_rsvd;
   assign bus_bipolar = q.bus_bip;
   assign bus_half_scale = q.bus_half;
   assign bus_reserved = q.bus_rsvd;

endmodule

// File: verification/rcsec_top_props.sv
`timescale 1ns/1ps
`include "rcsec_defs.svh"

module rcsec_top_props (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic lk_clk,
   input wire logic lk_rst_b,
   input wire logic lk_req,
   input wire logic lk_write,
   input wire logic [`RCSEC_ADDR_W-1:0] lk_addr,
   input wire logic [`RCSEC_DATA_W-1:0] lk_wdata,
   input wire logic lk_ready,
   input wire logic rate_ovr_pin,
   input wire logic rate_ovr_level,
   input wire logic snapshot_pulse,
   input wire logic accum_clear_pulse,
   input wire logic config_activate_pulse,
   input wire logic [`RCSEC_DATA_W-1:0] range_active,
   input wire logic [3:0] sense_bipolar,
   input wire logic [3:0] sense_half_scale,
   input wire logic [3:0] sense_reserved,
   input wire logic [3:0] bus_bipolar,
   input wire logic [3:0] bus_half_scale,
   input wire logic [3:0] bus_reserved
);
   logic [3:0] en_q;
   logic [23:0] dec_exp;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // Enables as last written by the host; the core sees them a bit later
   always_ff @(posedge lk_clk) begin
      if (!lk_rst_b) begin
         en_q <= 4'h0;
      end else if (lk_req && lk_ready && lk_write &&
                   lk_addr == `RCSEC_OFS_PINSTAT) begin
         en_q <= lk_wdata[4:1];
      end
   end

   // Expected decode of every active field, channel 1 in bit 0
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         dec_exp[20+i] = ^range_active[15-2*i -: 2];
         dec_exp[16+i] = range_active[15-2*i -: 2] == 2'h2;
         dec_exp[12+i] = range_active[15-2*i -: 2] == 2'h3;
         dec_exp[8+i] = ^range_active[7-2*i -: 2];
         dec_exp[4+i] = range_active[7-2*i -: 2] == 2'h2;
         dec_exp[i] = range_active[7-2*i -: 2] == 2'h3;
      end
   end

   sequence s_full;
      snapshot_pulse && accum_clear_pulse;
   endsequence
   sequence s_keep;
      snapshot_pulse && !accum_clear_pulse;
   endsequence

   property p_clr_snap;
      accum_clear_pulse |-> snapshot_pulse;
   endproperty
   a_clr_snap: assert property (p_clr_snap)
      else $error("accumulator clear without snapshot");
   property p_snap_one;
      snapshot_pulse |=> !snapshot_pulse;
   endproperty
   a_snap_one: assert property (p_snap_one)
      else $error("snapshot pulse longer than one cycle");
   property p_act;
      config_activate_pulse |-> snapshot_pulse && !lk_ready;
   endproperty
   a_act: assert property (p_act)
      else $error("config activated outside a host command");
   property p_hold;
      !$stable(range_active) |->
         config_activate_pulse || $past(config_activate_pulse);
   endproperty
   a_hold: assert property (p_hold)
      else $error("active range changed without activation");
   property p_dec;
      $stable(range_active) |-> {sense_bipolar, sense_half_scale,
         sense_reserved, bus_bipolar, bus_half_scale, bus_reserved} == dec_exp;
   endproperty
   a_dec: assert property (p_dec)
      else $error("range field decode wrong");
   property p_lvl_hi;
      $rose(rate_ovr_pin) ##1 rate_ovr_pin [*3] |-> rate_ovr_level;
   endproperty
   a_lvl_hi: assert property (p_lvl_hi)
      else $error("pin level not followed high");
   property p_lvl_lo;
      $fell(rate_ovr_pin) ##1 !rate_ovr_pin [*3] |-> !rate_ovr_level;
   endproperty
   a_lvl_lo: assert property (p_lvl_lo)
      else $error("pin level not followed low");
   property p_rise_full;
      $rose(rate_ovr_level) && en_q[3] |-> ##[0:2] s_full;
   endproperty
   a_rise_full: assert property (p_rise_full)
      else $error("no full update on rising edge");
   property p_rise_keep;
      $rose(rate_ovr_level) && en_q[3:2] == 2'h1 |-> ##[0:2] s_keep;
   endproperty
   a_rise_keep: assert property (p_rise_keep)
      else $error("no keep update on rising edge");
   property p_fall_full;
      $fell(rate_ovr_level) && en_q[1] |-> ##[0:2] s_full;
   endproperty
   a_fall_full: assert property (p_fall_full)
      else $error("no full update on falling edge");
   property p_fall_keep;
      $fell(rate_ovr_level) && en_q[1:0] == 2'h1 |-> ##[0:2] s_keep;
   endproperty
   a_fall_keep: assert property (p_fall_keep)
      else $error("no keep update on falling edge");
endmodule

bind rcsec_top rcsec_top_props chk_u (
   .ref_clk(ref_clk), .rst_b(rst_b), .lk_clk(lk_clk),
   .lk_rst_b(lk_rst_b), .lk_req(lk_req), .lk_write(lk_write),
   .lk_addr(lk_addr), .lk_wdata(lk_wdata), .lk_ready(lk_ready),
   .rate_ovr_pin(rate_ovr_pin), .rate_ovr_level(rate_ovr_level),
   .snapshot_pulse(snapshot_pulse), .accum_clear_pulse(accum_clear_pulse),
   .config_activate_pulse(config_activate_pulse),
   .range_active(range_active), .sense_bipolar(sense_bipolar),
   .sense_half_scale(sense_half_scale), .sense_reserved(sense_reserved),
   .bus_bipolar(bus_bipolar), .bus_half_scale(bus_half_scale),
   .bus_reserved(bus_reserved)
);

// File: verification/rcsec_host_model.sv
`timescale 1ns/1ps
`include "rcsec_defs.svh"

module rcsec_host_model #(
   parameter int SETTLE_CYC = 4
) (
   input wire logic lk_clk,
   input wire logic lk_ready,
   input wire logic lk_done,
   input wire logic [`RCSEC_DATA_W-1:0] lk_rdata,
   output logic lk_req,
   output logic lk_write,
   output logic [`RCSEC_ADDR_W-1:0] lk_addr,
   output logic [`RCSEC_DATA_W-1:0] lk_wdata
);
   // Accesses that never saw their answer
   int timeouts = 0;

   // Idle bus at time zero
   initial begin
      lk_req = 1'b0;
      lk_write = 1'b0;
      lk_addr = 8'h00;
      lk_wdata = 16'h0000;
   end

   // One access; after the taking edge the qualifiers no longer hold data
   task automatic access(input logic wr, input logic [7:0] a,
                         input logic [15:0] d, output logic [15:0] r);
      int n;
      n = 0;
      @(negedge lk_clk);
      while (lk_ready !== 1'b1) @(negedge lk_clk);
      lk_req = 1'b1;
      lk_write = wr;
      lk_addr = a;
      lk_wdata = d;
      @(posedge lk_clk);
      @(negedge lk_clk);
      lk_req = 1'b0;
      lk_write = ~wr;
      lk_addr = ~a;
      lk_wdata = ~d;
      while (lk_done !== 1'b1 && n < 40) begin
         @(negedge lk_clk);
         n++;
      end
      if (lk_done !== 1'b1) timeouts++;
      r = lk_rdata;
      // Results are only trusted after a settle time past any update
      if (wr) repeat (SETTLE_CYC) @(negedge lk_clk);
   endtask
endmodule

// File: verification/rcsec_top_bench.sv
`timescale 1ns/1ps
`include "rcsec_defs.svh"

module rcsec_top_bench;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [15:0] d;
      logic [15:0] exp;
   } rcsec_row_t;
   logic ref_clk = 1'b0;
   logic lk_clk = 1'b0;
   logic rst_b = 1'b0;
   logic lk_rst_b = 1'b0;
   logic rate_ovr_pin = 1'b0;
   logic lk_req, lk_write, lk_ready, lk_done, rate_ovr_level;
   logic snapshot_pulse, accum_clear_pulse, config_activate_pulse;
   logic [7:0] lk_addr;
   logic [15:0] lk_wdata, lk_rdata, range_active, rd;
   logic [3:0] sense_bipolar, sense_half_scale, sense_reserved;
   logic [3:0] bus_bipolar, bus_half_scale, bus_reserved;
   int bad_count = 0;
   int num_checks = 0;
   int snaps = 0;
   int clrs = 0;
   int acts = 0;
   int s0, c0, a0;
   // Register rows: write flag, offset, data, expected read
   rcsec_row_t rows [10] = '{
      '{1'b0, 8'h1d, 16'h0000, 16'h0000}, '{1'b0, 8'h20, 16'h0000, 16'h0000},
      '{1'b1, 8'h1d, 16'he41b, 16'h0000}, '{1'b0, 8'h1d, 16'h0000, 16'he41b},
      '{1'b1, 8'h20, 16'hffff, 16'h0000}, '{1'b0, 8'h20, 16'h0000, 16'h001e},
      '{1'b1, 8'h05, 16'hffff, 16'h0000}, '{1'b0, 8'h05, 16'h0000, 16'h0000},
      '{1'b1, 8'h20, 16'h0000, 16'h0000}, '{1'b0, 8'h20, 16'h0000, 16'h0000}};
   // Pin rows: new level, {snapshots, clears} expected, enables, status
   rcsec_row_t pins [5] = '{
      '{1'b1, 8'h03, 16'h0018, 16'h00d8}, '{1'b0, 8'h02, 16'h0002, 16'h0062},
      '{1'b1, 8'h02, 16'h0008, 16'h00e8}, '{1'b0, 8'h03, 16'h0004, 16'h0064},
      '{1'b1, 8'h00, 16'h0000, 16'h00e0}};
   logic [7:0] cmds [3] = '{`RCSEC_OFS_REFRESH, `RCSEC_OFS_GCALL,
                            `RCSEC_OFS_KEEP};
   logic [15:0] vals [3] = '{16'he41b, 16'h1b24, 16'h5555};

   rcsec_top dut_u (
      .ref_clk, .rst_b, .lk_clk, .lk_rst_b, .lk_req, .lk_write, .lk_addr,
      .lk_wdata, .lk_ready, .lk_done, .lk_rdata, .rate_ovr_pin,
      .rate_ovr_level, .snapshot_pulse, .accum_clear_pulse,
      .config_activate_pulse, .range_active, .sense_bipolar,
      .sense_half_scale, .sense_reserved, .bus_bipolar, .bus_half_scale,
      .bus_reserved
   );
   rcsec_host_model host_u (
      .lk_clk, .lk_ready, .lk_done, .lk_rdata, .lk_req, .lk_write,
      .lk_addr, .lk_wdata
   );

   // System clock; link clock offset so edges never coincide
   always #25 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #15 lk_clk = ~lk_clk;
   end

   // Pulse tallies at the falling edge, where the pulses have settled
   always @(negedge ref_clk) begin
      if (snapshot_pulse === 1'b1) snaps++;
      if (accum_clear_pulse === 1'b1) clrs++;
      if (config_activate_pulse === 1'b1) acts++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (bad_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog, far beyond the expected run of some 15 us
   initial begin
      #400_000;
      bad_count++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_b = 1'b1;
      lk_rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      foreach (rows[i]) begin
         host_u.access(rows[i].wr, rows[i].a, rows[i].d, rd);
         if (!rows[i].wr) check(rd, rows[i].exp);
      end
      // Each command activates the pending range; clears only on full ones
      foreach (cmds[k]) begin
         if (k > 0) host_u.access(1'b1, `RCSEC_OFS_RANGE, vals[k], rd);
         check(range_active, (k > 0) ? vals[k-1] : 16'h0000);
         s0 = snaps;
         c0 = clrs;
         a0 = acts;
         host_u.access(1'b1, cmds[k], 16'hffff, rd);
         check(range_active, vals[k]);
         check(16'(snaps - s0), 16'h0001);
         check(16'(clrs - c0), (k < 2) ? 16'h0001 : 16'h0000);
         check(16'(acts - a0), 16'h0001);
         if (k == 0) begin
            check({sense_bipolar, sense_half_scale, sense_reserved,
                   bus_bipolar}, 16'h6216);
            check({8'h00, bus_half_scale, bus_reserved}, 16'h0048);
         end
      end
      // Pin edges under five enable mixes; no pending config may activate
      foreach (pins[i]) begin
         host_u.access(1'b1, `RCSEC_OFS_PINSTAT, pins[i].d, rd);
         s0 = snaps;
         c0 = clrs;
         a0 = acts;
         @(negedge ref_clk);
         rate_ovr_pin = pins[i].wr;
         repeat (8) @(negedge ref_clk);
         check(16'(snaps - s0), {15'h0, pins[i].a[1]});
         check(16'(clrs - c0), {15'h0, pins[i].a[0]});
         check(16'(acts - a0), 16'h0000);
         host_u.access(1'b0, `RCSEC_OFS_PINSTAT, 16'h0000, rd);
         check(rd, pins[i].exp);
      end
      // Keep update leaves the edge flags, general call clears them
      host_u.access(1'b1, `RCSEC_OFS_KEEP, 16'h0000, rd);
      host_u.access(1'b0, `RCSEC_OFS_PINSTAT, 16'h0000, rd);
      check(rd, 16'h00e0);
      host_u.access(1'b1, `RCSEC_OFS_GCALL, 16'h0000, rd);
      host_u.access(1'b0, `RCSEC_OFS_PINSTAT, 16'h0000, rd);
      check(rd, 16'h0080);
      // Reset mid-run with the pin high: no false rise may follow
      @(negedge ref_clk);
      rst_b = 1'b0;
      lk_rst_b = 1'b0;
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      lk_rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(range_active, 16'h0000);
      host_u.access(1'b0, `RCSEC_OFS_PINSTAT, 16'h0000, rd);
      check(rd, 16'h0080);
      host_u.access(1'b0, `RCSEC_OFS_RANGE, 16'h0000, rd);
      check(rd, 16'h0000);
      check(16'(host_u.timeouts), 16'h0000);
      print_verdict();
   end
endmodule
